// File: ecal_regs.svh
// register offsets, field positions, reset values and image addresses
`ifndef ECAL_REGS_SVH
`define ECAL_REGS_SVH
`define ECAL_ADDR_BOOST 8'h10
`define ECAL_ADDR_STCMD 8'h11
`define ECAL_ADDR_CTRL 8'hFF
`define ECAL_STCMD_ATTACH 0
`define ECAL_STCMD_SOFTRST 1
`define ECAL_BOOST_RST 8'h00
`define ECAL_SIGNATURE 8'hA5
`define ECAL_DEF_MAC 48'hFFFFFFFFFFFF
`define ECAL_DEF_FS_POLL 8'h01
`define ECAL_DEF_HS_POLL 8'h04
`define ECAL_DEF_CFG_FLAGS 8'h05
`define ECAL_DEF_MAX_POWER 8'h01
`define ECAL_DEF_VID 16'h1111
`define ECAL_DEF_PID 16'h2222
`define ECAL_EE_SIG 8'h00
`define ECAL_EE_MAC_LAST 8'h06
`define ECAL_EE_ETH_LAST 8'h0A
`define ECAL_EE_VID_LO 8'h20
`define ECAL_EE_HUB_BOOST 8'h2A
`endif

// File: ecal_pkg.sv
// types of the configuration loader
package ecal_pkg;
	typedef enum logic [1:0] {ECAL_LOAD_FULL, ECAL_LOAD_MAC, ECAL_LOAD_ETH} ecal_kind_t;
	typedef enum logic [2:0] {ECAL_IDLE, ECAL_REQ, ECAL_WAIT, ECAL_NEXT, ECAL_DONE} ecal_state_t;
endpackage

// File: ecal_loader.sv
// configuration loader: image fetch, defaults, boost and status registers
`timescale 1ns/1ps
`include "ecal_regs.svh"
module ecal_loader (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic POR_N,
	input wire logic USB_RESET,
	input wire logic ETH_RELOAD,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	output logic EE_RD_REQ,
	output logic [7:0] EE_RD_ADDR,
	input wire logic EE_RD_VALID,
	input wire logic [7:0] EE_RD_DATA,
	output logic [47:0] MAC_ADDR,
	output logic [7:0] FS_POLL,
	output logic [7:0] HS_POLL,
	output logic [7:0] CFG_FLAGS,
	output logic [7:0] MAX_POWER,
	output logic [15:0] VENDOR_ID,
	output logic [15:0] PRODUCT_ID,
	output logic [7:0] DOWNSTREAM_DRIVE_BOOST,
	output logic USB_ATTACH,
	output logic LOAD_DONE
);
	import ecal_pkg::*;
	// two-stage synchronisers for pin-level resets
	logic [1:0] sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
	logic usb_prev_ff, nxt_usb_prev;
	always_comb begin
		nxt_sync1 = {USB_RESET, POR_N};
		nxt_sync2 = sync1_ff;
		nxt_usb_prev = sync2_ff[1];
	end
	always_ff @(posedge SYS_CLK) begin
		sync1_ff <= nxt_sync1;
		sync2_ff <= nxt_sync2;
		usb_prev_ff <= nxt_usb_prev;
	end
	logic hard_rst;
	logic usb_rise;
	assign hard_rst = !RST_N || !sync2_ff[0];
	assign usb_rise = sync2_ff[1] && !usb_prev_ff;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	ecal_state_t state_ff, nxt_state;
	ecal_kind_t kind_ff, nxt_kind;
	logic [7:0] addr_ff, nxt_addr;
	logic [7:0] last_ff, nxt_last;
	logic [47:0] mac_ff, nxt_mac;
	logic [7:0] fs_ff, nxt_fs, hs_ff, nxt_hs, flags_ff, nxt_flags, pwr_ff, nxt_pwr;
	logic [15:0] vid_ff, nxt_vid, pid_ff, nxt_pid;
	logic [7:0] boost_ff, nxt_boost;
	logic attach_ff, nxt_attach, attach_wr_ff, nxt_attach_wr;
	logic done_ff, nxt_done, req_ff, nxt_req;
	logic [7:0] rdata_ff, nxt_rdata;
	logic soft_ff, nxt_soft;
	logic wr_ok, soft_go;

	assign wr_ok = REG_WR && !attach_ff;
	assign soft_go = wr_ok && hit(REG_ADDR, `ECAL_ADDR_STCMD) && REG_WDATA[`ECAL_STCMD_SOFTRST];

	always_comb begin
		nxt_state = state_ff;
		nxt_kind = kind_ff;
		nxt_addr = addr_ff;
		nxt_last = last_ff;
		nxt_mac = mac_ff;
		nxt_fs = fs_ff;
		nxt_hs = hs_ff;
		nxt_flags = flags_ff;
		nxt_pwr = pwr_ff;
		nxt_vid = vid_ff;
		nxt_pid = pid_ff;
		nxt_boost = boost_ff;
		nxt_attach = attach_ff;
		nxt_attach_wr = attach_wr_ff;
		nxt_done = done_ff;
		nxt_req = 1'b0;
		nxt_soft = 1'b0;
		nxt_rdata = 8'h00;
		if (REG_RD) begin
			if (hit(REG_ADDR, `ECAL_ADDR_BOOST)) begin
				nxt_rdata = {boost_ff[7:2], 2'b00};
			end else if (hit(REG_ADDR, `ECAL_ADDR_STCMD)) begin
				nxt_rdata = {6'h00, soft_ff, attach_ff};
			end else if (hit(REG_ADDR, `ECAL_ADDR_CTRL)) begin
				nxt_rdata = {7'h00, done_ff};
			end
		end
		if (wr_ok && hit(REG_ADDR, `ECAL_ADDR_BOOST)) begin
			nxt_boost = {REG_WDATA[7:2], 2'b00};
		end
		if (REG_WR && hit(REG_ADDR, `ECAL_ADDR_STCMD) && !attach_wr_ff) begin
			nxt_attach = REG_WDATA[`ECAL_STCMD_ATTACH];
			nxt_attach_wr = 1'b1;
		end
		if (soft_go) begin
			nxt_boost = `ECAL_BOOST_RST;
			// bit shows one cycle, then clears
			nxt_soft = 1'b1;
		end
		unique case (state_ff)
			ECAL_IDLE: begin
				nxt_state = ECAL_IDLE;
			end
			ECAL_REQ: begin
				nxt_req = 1'b1;
				nxt_state = ECAL_WAIT;
			end
			ECAL_WAIT: begin
				if (EE_RD_VALID) begin
					nxt_state = ECAL_NEXT;
					if (addr_ff == `ECAL_EE_SIG) begin
						if (EE_RD_DATA != `ECAL_SIGNATURE) begin
							nxt_state = ECAL_DONE;
						end
					end else if (addr_ff <= `ECAL_EE_MAC_LAST) begin
						nxt_mac = {mac_ff[39:0], EE_RD_DATA};
					end else if (addr_ff == 8'h07) begin
						nxt_fs = EE_RD_DATA;
					end else if (addr_ff == 8'h08) begin
						nxt_hs = EE_RD_DATA;
					end else if (addr_ff == 8'h09) begin
						nxt_flags = EE_RD_DATA;
					end else if (addr_ff == `ECAL_EE_ETH_LAST) begin
						nxt_pwr = EE_RD_DATA;
					end else if (addr_ff == `ECAL_EE_VID_LO) begin
						nxt_vid = {vid_ff[15:8], EE_RD_DATA};
					end else if (addr_ff == 8'h21) begin
						nxt_vid = {EE_RD_DATA, vid_ff[7:0]};
					end else if (addr_ff == 8'h22) begin
						nxt_pid = {pid_ff[15:8], EE_RD_DATA};
					end else if (addr_ff == 8'h23) begin
						nxt_pid = {EE_RD_DATA, pid_ff[7:0]};
					end else if (addr_ff == `ECAL_EE_HUB_BOOST) begin
						nxt_boost = {EE_RD_DATA[7:2], 2'b00};
					end
				end
			end
			ECAL_NEXT: begin
				if (addr_ff == last_ff) begin
					nxt_state = ECAL_DONE;
				end else begin
					if (addr_ff == `ECAL_EE_ETH_LAST && kind_ff == ECAL_LOAD_FULL) begin
						nxt_addr = `ECAL_EE_VID_LO;
					end else if (addr_ff == 8'h23) begin
						nxt_addr = `ECAL_EE_HUB_BOOST;
					end else begin
						nxt_addr = addr_ff + 8'h01;
					end
					nxt_state = ECAL_REQ;
				end
			end
			ECAL_DONE: begin
				nxt_done = 1'b1;
				nxt_state = ECAL_IDLE;
			end
		endcase
		if (usb_rise || ETH_RELOAD || soft_go) begin
			nxt_addr = `ECAL_EE_SIG;
			nxt_done = 1'b0;
			nxt_state = ECAL_REQ;
			if (usb_rise) begin
				nxt_kind = ECAL_LOAD_MAC;
				nxt_last = `ECAL_EE_MAC_LAST;
			end else begin
				nxt_kind = ECAL_LOAD_ETH;
				nxt_last = `ECAL_EE_ETH_LAST;
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (hard_rst) begin
			mac_ff <= `ECAL_DEF_MAC;
			fs_ff <= `ECAL_DEF_FS_POLL;
			hs_ff <= `ECAL_DEF_HS_POLL;
			flags_ff <= `ECAL_DEF_CFG_FLAGS;
			pwr_ff <= `ECAL_DEF_MAX_POWER;
			vid_ff <= `ECAL_DEF_VID;
			pid_ff <= `ECAL_DEF_PID;
			boost_ff <= `ECAL_BOOST_RST;
			attach_ff <= 1'b1;
			attach_wr_ff <= 1'b0;
			state_ff <= ECAL_REQ;
			kind_ff <= ECAL_LOAD_FULL;
			addr_ff <= `ECAL_EE_SIG;
			last_ff <= `ECAL_EE_HUB_BOOST;
			done_ff <= 1'b0;
			req_ff <= 1'b0;
			soft_ff <= 1'b0;
			rdata_ff <= 8'h00;
		end else begin
			mac_ff <= nxt_mac;
			fs_ff <= nxt_fs;
			hs_ff <= nxt_hs;
			flags_ff <= nxt_flags;
			pwr_ff <= nxt_pwr;
			vid_ff <= nxt_vid;
			pid_ff <= nxt_pid;
			boost_ff <= nxt_boost;
			attach_ff <= nxt_attach;
			attach_wr_ff <= nxt_attach_wr;
			state_ff <= nxt_state;
			kind_ff <= nxt_kind;
			addr_ff <= nxt_addr;
			last_ff <= nxt_last;
			done_ff <= nxt_done;
			req_ff <= nxt_req;
			soft_ff <= nxt_soft;
			rdata_ff <= nxt_rdata;
		end
	end

	assign REG_RDATA = rdata_ff;
	assign EE_RD_REQ = req_ff;
	assign EE_RD_ADDR = addr_ff;
	assign MAC_ADDR = mac_ff;
	assign FS_POLL = fs_ff;
	assign HS_POLL = hs_ff;
	assign CFG_FLAGS = flags_ff;
	assign MAX_POWER = pwr_ff;
	assign VENDOR_ID = vid_ff;
	assign PRODUCT_ID = pid_ff;
	assign DOWNSTREAM_DRIVE_BOOST = boost_ff;
	// attach signalled while bit is one
	assign USB_ATTACH = attach_ff;
	assign LOAD_DONE = done_ff;
endmodule

// File: ecal_loader_checker.sv
// assertions on the configuration loader ports
`timescale 1ns/1ps
module ecal_loader_checker (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_RDATA,
	input wire logic EE_RD_REQ,
	input wire logic [7:0] EE_RD_ADDR,
	input wire logic EE_RD_VALID,
	input wire logic [7:0] EE_RD_DATA,
	input wire logic [7:0] DOWNSTREAM_DRIVE_BOOST,
	input wire logic USB_ATTACH,
	input wire logic LOAD_DONE
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	wire bw = REG_WR && REG_ADDR == 8'h10 && LOAD_DONE;
	sequence s_first(ok);
		EE_RD_VALID && EE_RD_ADDR == 8'h00 && (EE_RD_DATA == 8'hA5) == ok;
	endsequence
	a_boost_rsvd: assert property (DOWNSTREAM_DRIVE_BOOST[1:0] == 2'h0) else $error("boost low bits");
	a_boost_write: assert property (bw && !USB_ATTACH |=> DOWNSTREAM_DRIVE_BOOST == ($past(REG_WDATA) & 8'hFC))
		else $error("boost write lost");
	a_boost_lock: assert property (bw && USB_ATTACH |=> $stable(DOWNSTREAM_DRIVE_BOOST)) else $error("lock broken");
	a_attach_keep: assert property (!USB_ATTACH |=> !USB_ATTACH) else $error("attach set again");
	a_stcmd_read: assert property (REG_RD && REG_ADDR == 8'h11 |=> REG_RDATA[7:2] == 6'h00
		&& REG_RDATA[0] == $past(USB_ATTACH)) else $error("status read wrong");
	a_sig_skip: assert property (s_first(1'h0) |=> (!EE_RD_REQ) [*4]) else $error("load not skipped");
	a_skip_done: assert property (s_first(1'h0) |-> ##[1:4] LOAD_DONE) else $error("skip not done");
	a_sig_next: assert property (s_first(1'h1) |-> ##3 EE_RD_REQ && EE_RD_ADDR == 8'h01) else $error("no mac fetch");
	a_addr_up: assert property (EE_RD_REQ && EE_RD_ADDR != 8'h00 |-> EE_RD_ADDR > $past(EE_RD_ADDR, 2))
		else $error("fetch not ascending");
endmodule

// File: ecal_eeprom_model.sv
// behavioural model of the serial configuration memory
`timescale 1ns/1ps
module ecal_eeprom_model (
	input wire logic clk,
	input wire logic req,
	input wire logic [7:0] addr,
	input wire logic sig_ok,
	input wire logic [7:0] ofs,
	output logic valid,
	output logic [7:0] data
);
	logic busy = 0;
	logic [1:0] cnt = 0;
	initial valid = 0;
	initial data = 0;
	// odd addresses answer slowly; data toggles when idle
	always @(posedge clk) begin
		valid <= 0;
		data <= ~data;
		if (req) begin
			busy <= 1;
			cnt <= addr[0] ? 2'h2 : 2'h0;
		end else if (busy && cnt != 0) begin
			cnt <= cnt - 2'h1;
		end else if (busy) begin
			busy <= 0;
			valid <= 1;
			data <= addr == 8'h00 ? (sig_ok ? 8'hA5 : 8'h5A) : addr + ofs;
		end
	end
endmodule

// File: ecal_loader_test.sv
// self-checking bench of the configuration loader
`timescale 1ns/1ps
`include "ecal_regs.svh"
module ecal_loader_test;
	logic SYS_CLK = 0, RST_N = 0, POR_N = 1, USB_RESET = 0, ETH_RELOAD = 0, REG_WR = 0, REG_RD = 0;
	logic EE_RD_REQ, EE_RD_VALID, USB_ATTACH, LOAD_DONE, sig = 0;
	logic [7:0] REG_ADDR = 0, REG_WDATA = 0, REG_RDATA, EE_RD_ADDR, EE_RD_DATA, FS_POLL, HS_POLL;
	logic [7:0] CFG_FLAGS, MAX_POWER, DOWNSTREAM_DRIVE_BOOST, ofs = 8'h30;
	logic [7:0] bv [2] = '{8'hE7, 8'h1B};
	logic [47:0] MAC_ADDR;
	logic [15:0] VENDOR_ID, PRODUCT_ID;
	int failures = 0, checks = 0;
	always #20 SYS_CLK = ~SYS_CLK;
	ecal_loader uut (.*);
	ecal_eeprom_model ee (.clk(SYS_CLK), .req(EE_RD_REQ), .addr(EE_RD_ADDR), .sig_ok(sig), .ofs(ofs),
		.valid(EE_RD_VALID), .data(EE_RD_DATA));
	task chk(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge SYS_CLK);
		REG_ADDR <= ad;
		REG_WDATA <= d;
		REG_WR <= 1;
		@(posedge SYS_CLK);
		REG_WR <= 0;
	endtask
	task rd(input logic [7:0] ad, input logic [7:0] exp);
		@(posedge SYS_CLK);
		REG_ADDR <= ad;
		REG_RD <= 1;
		@(posedge SYS_CLK);
		REG_RD <= 0;
		#1 chk(REG_RDATA, exp);
	endtask
	task wait_load();
		int i;
		for (i = 0; i < 20 && LOAD_DONE; i++) @(posedge SYS_CLK);
		for (i = 0; i < 400 && !LOAD_DONE; i++) @(posedge SYS_CLK);
		if (LOAD_DONE !== 1'h1) begin
			failures++;
			wrap_up();
		end
	endtask
	task hard();
		@(posedge SYS_CLK);
		RST_N <= 0;
		repeat (2) @(posedge SYS_CLK);
		RST_N <= 1;
		wait_load();
	endtask
	task eth(input logic [7:0] b);
		chk(MAC_ADDR, {b + 8'h01, b + 8'h02, b + 8'h03, b + 8'h04, b + 8'h05, b + 8'h06});
		chk({FS_POLL, HS_POLL, CFG_FLAGS, MAX_POWER}, {b + 8'h07, b + 8'h08, b + 8'h09, b + 8'h0A});
	endtask
	task dflt();
		chk(MAC_ADDR, 48'hFFFFFFFFFFFF);
		chk({FS_POLL, HS_POLL, CFG_FLAGS, MAX_POWER}, 32'h01040501);
		chk({VENDOR_ID, PRODUCT_ID, DOWNSTREAM_DRIVE_BOOST, USB_ATTACH}, {`ECAL_DEF_VID, `ECAL_DEF_PID, 9'h001});
	endtask
	task wrap_up();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		hard();
		dflt();
		wr(8'h10, 8'hE4);
		rd(8'h10, 8'h00);
		wr(8'h11, 8'h00);
		wr(8'h11, 8'h01);
		rd(8'h11, 8'h00);
		foreach (bv[i]) begin
			wr(8'h10, bv[i]);
			rd(8'h10, bv[i] & 8'hFC);
		end
		rd(8'hFF, 8'h01);
		rd(8'h20, 8'h00);
		$display("register test done");
		sig <= 1;
		hard();
		eth(8'h30);
		chk({VENDOR_ID, PRODUCT_ID, DOWNSTREAM_DRIVE_BOOST, USB_ATTACH}, {16'h5150, 16'h5352, 9'h0B1});
		$display("full load test done");
		ofs <= 8'h40;
		USB_RESET <= 1;
		wait_load();
		USB_RESET <= 0;
		chk({MAC_ADDR, FS_POLL}, 56'h41424344454637);
		ofs <= 8'h50;
		ETH_RELOAD <= 1;
		@(posedge SYS_CLK);
		ETH_RELOAD <= 0;
		wait_load();
		eth(8'h50);
		chk({VENDOR_ID, DOWNSTREAM_DRIVE_BOOST}, 24'h515058);
		ofs <= 8'h60;
		wr(8'h11, 8'h00);
		wr(8'h11, 8'h02);
		wait_load();
		rd(8'h11, 8'h00);
		chk(DOWNSTREAM_DRIVE_BOOST, 8'h00);
		eth(8'h60);
		$display("reload test done");
		sig <= 0;
		hard();
		dflt();
		wrap_up();
	end
endmodule
bind ecal_loader ecal_loader_checker chk_i (.*);
